// file: pkg/pab_cfg.svh
// Constants of the secondary-bus arbiter: offset, field layout, reset value
// and timing counts. Assumes inclusion by bare name from design files.
`ifndef PAB_CFG_SVH
`define PAB_CFG_SVH

`define PAB_ARB_OFFSET   8'h48
`define PAB_ARB_RESET    32'h0040_801F
`define PAB_ARB_RW_MASK  32'h07DF_FE1F
`define PAB_EN_LSB       0
`define PAB_EXT_BIT      9
`define PAB_BMTO_BIT     10
`define PAB_BMRF_BIT     11
`define PAB_FAIR_LSB     12
`define PAB_TOG_BIT      20
`define PAB_PRIO_LSB     22
`define PAB_BM_TIMEOUT_CYC 16
`define PAB_TOG_DELAY_CYC  2

`endif

// file: pkg/pab_pkg.sv
// Types shared by the secondary-bus arbiter files.
// Assumes nothing of its surroundings.
package pab_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_OWN
  } pab_state_t;

  typedef logic [4:0] pab_vec_t;

endpackage

// file: src/pab_cfg_reg.sv
// Configuration word at offset 48h: arbitration enables, mode and priority.
// Assumes a single-cycle configuration access port on the PCI clock.
`include "pab_cfg.svh"

module pab_cfg_reg (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cfg_sel,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic      [4:0]  cfg_en,
  output logic             cfg_ext,
  output logic             cfg_bmto,
  output logic             cfg_bmrf,
  output logic      [7:0]  cfg_fair,
  output logic             cfg_tog,
  output logic      [4:0]  cfg_prio
);

  logic [31:0] word;
  logic [31:0] next_word;
  logic [31:0] next_rdata;
  logic [31:0] lane_mask;
  logic        hit;

  always_comb begin
    hit        = cfg_sel && (cfg_addr == `PAB_ARB_OFFSET);
    lane_mask  = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                  {8{cfg_be[1]}}, {8{cfg_be[0]}}} & `PAB_ARB_RW_MASK;
    next_word  = word;
    next_rdata = 32'h0000_0000;
    if (hit && cfg_wr) begin
      next_word = (word & ~lane_mask) | (cfg_wdata & lane_mask);
    end
    if (hit && !cfg_wr) begin
      next_rdata = word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word      <= `PAB_ARB_RESET;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      word      <= next_word;
      cfg_rdata <= next_rdata;
    end
  end

  assign cfg_en   = word[`PAB_EN_LSB +: 5];
  assign cfg_ext  = word[`PAB_EXT_BIT];
  assign cfg_bmto = word[`PAB_BMTO_BIT];
  assign cfg_bmrf = word[`PAB_BMRF_BIT];
  assign cfg_fair = word[`PAB_FAIR_LSB +: 8];
  assign cfg_tog  = word[`PAB_TOG_BIT];
  assign cfg_prio = word[`PAB_PRIO_LSB +: 5];

endmodule

// file: src/pab_arbiter.sv
// Internal arbiter of the secondary PCI bus: bridge request plus four masters.
// Assumes req_n, frame_n and irdy_n come straight from pins; int_req is local.
`include "pab_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - External arbiter bit set disables all grants; clear at reset.
// - With timeout on, count 16 idle cycles while a grant waits for FRAME#.
// - Timeout expiry withdraws the grant; no timeout when the enable is 0.
// - Without refresh a broken master stays ignored until reset.
// - With refresh, broken state clears once all enabled, unbroken others were served once.
// - Eight-bit fairness field, reset 08h, sets hold time under contention.
// - Fairness counter reloads from the field on every new grant.
// - Fairness counter starts decrementing only after FRAME# falls.
// - Fairness zero keeps the grant until the owner drops its request.
// - Toggle on: GNT# released one clock, two clocks after FRAME# falls.
// - Toggle off: GNT# stays asserted through the owner's transaction.
// - Per-requester priority bit; bridge resets high, masters low.
// - Per-requester enable bit, reset enabled; disabled never granted.
module pab_arbiter #(
  parameter int BM_CYCLES = `PAB_BM_TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cfg_sel,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        int_req,
  output logic             int_gnt,
  input  wire logic [4:1]  req_n,
  output logic      [4:1]  gnt_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  output logic      [4:0]  broken_mask
);

  if (BM_CYCLES < 1 || BM_CYCLES > 255) begin : g_bad_param
    $error("BM_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] BM_LAST  = 8'(BM_CYCLES - 1);
  localparam logic [1:0] TOG_STEP = 2'(`PAB_TOG_DELAY_CYC);

  logic [4:0] cfg_en;
  logic       cfg_ext;
  logic       cfg_bmto;
  logic       cfg_bmrf;
  logic [7:0] cfg_fair;
  logic       cfg_tog;
  logic [4:0] cfg_prio;

  pab_cfg_reg u_cfg (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cfg_sel   (cfg_sel),
    .cfg_wr    (cfg_wr),
    .cfg_addr  (cfg_addr),
    .cfg_be    (cfg_be),
    .cfg_wdata (cfg_wdata),
    .cfg_rdata (cfg_rdata),
    .cfg_en    (cfg_en),
    .cfg_ext   (cfg_ext),
    .cfg_bmto  (cfg_bmto),
    .cfg_bmrf  (cfg_bmrf),
    .cfg_fair  (cfg_fair),
    .cfg_tog   (cfg_tog),
    .cfg_prio  (cfg_prio)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:1] req_s1;
  logic [4:1] req_s2;
  logic       frame_s1;
  logic       frame_s2;
  logic       frame_prev;
  logic       irdy_s1;
  logic       irdy_s2;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_s1     <= 4'hF;
      req_s2     <= 4'hF;
      frame_s1   <= 1'b1;
      frame_s2   <= 1'b1;
      frame_prev <= 1'b1;
      irdy_s1    <= 1'b1;
      irdy_s2    <= 1'b1;
    end else begin
      req_s1     <= req_n;
      req_s2     <= req_s1;
      frame_s1   <= frame_n;
      frame_s2   <= frame_s1;
      frame_prev <= frame_s2;
      irdy_s1    <= irdy_n;
      irdy_s2    <= irdy_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic pab_pkg::pab_vec_t onehot(input logic [2:0] idx);
    onehot = 5'h01 << idx;
  endfunction

  // Rotating search from the requester after last over one level's set
  function automatic logic [2:0] rotate(input pab_pkg::pab_vec_t set,
                                        input logic [2:0] last);
    logic [2:0] idx;
    rotate = last;
    idx    = last;
    for (int k = 0; k < 5; k++) begin
      idx = (idx == 3'd4) ? 3'd0 : 3'(idx + 3'd1);
      if (set[idx] && rotate == last && !(set[last] && idx == last)) begin
        rotate = idx;
      end
    end
    for (int k = 0; k < 5; k++) begin
      if (set == onehot(3'(k))) begin
        rotate = 3'(k);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration state
  pab_pkg::pab_state_t state;
  pab_pkg::pab_state_t next_state;
  logic [2:0] owner;
  logic [2:0] next_owner;
  logic [2:0] last;
  logic [2:0] next_last;
  logic [7:0] fair_cnt;
  logic [7:0] next_fair_cnt;
  logic [7:0] bm_cnt;
  logic [7:0] next_bm_cnt;
  logic [1:0] tog_cnt;
  logic [1:0] next_tog_cnt;
  pab_pkg::pab_vec_t broken;
  pab_pkg::pab_vec_t next_broken;
  pab_pkg::pab_vec_t served;
  pab_pkg::pab_vec_t next_served;
  pab_pkg::pab_vec_t gnt_q;
  pab_pkg::pab_vec_t next_gnt;
  pab_pkg::pab_vec_t req;
  pab_pkg::pab_vec_t elig;
  pab_pkg::pab_vec_t others;
  logic [2:0] win;
  logic       own_ok;
  logic       frame_fall;
  logic       bus_idle;

  always_comb begin
    req        = {~req_s2, int_req};
    elig       = req & cfg_en & ~broken;
    others     = elig & ~onehot(owner);
    own_ok     = req[owner] && cfg_en[owner];
    frame_fall = frame_prev && !frame_s2;
    bus_idle   = frame_s2 && irdy_s2;
    win = (|(elig & cfg_prio)) ? rotate(elig & cfg_prio, last)
                               : rotate(elig, last);
    next_state    = state;
    next_owner    = owner;
    next_last     = last;
    next_fair_cnt = fair_cnt;
    next_bm_cnt   = bm_cnt;
    next_tog_cnt  = tog_cnt;
    next_broken   = broken;
    next_served   = served;
    unique case (state)
      pab_pkg::ST_IDLE: begin
        if (!cfg_ext && |elig) begin
          next_state    = pab_pkg::ST_WAIT;
          next_owner    = win;
          next_last     = win;
          next_fair_cnt = cfg_fair;
          next_bm_cnt   = 8'h00;
          next_served   = served | onehot(win);
        end
      end
      pab_pkg::ST_WAIT: begin
        if (cfg_ext || !own_ok) begin
          next_state = pab_pkg::ST_IDLE;
        end else if (frame_fall) begin
          next_state   = pab_pkg::ST_OWN;
          next_tog_cnt = 2'd1;
        end else if (cfg_bmto && bus_idle) begin
          if (bm_cnt == BM_LAST) begin
            next_state  = pab_pkg::ST_IDLE;
            next_broken = broken | onehot(owner);
            next_served = 5'h00;
          end else begin
            next_bm_cnt = 8'(bm_cnt + 8'h01);
          end
        end
      end
      pab_pkg::ST_OWN: begin
        if (cfg_ext || !own_ok) begin
          next_state = pab_pkg::ST_IDLE;
        end else begin
          if (tog_cnt != 2'd3) begin
            next_tog_cnt = 2'(tog_cnt + 2'd1);
          end
          if (cfg_fair != 8'h00 && |others) begin
            if (fair_cnt == 8'h00) begin
              next_state = pab_pkg::ST_IDLE;
            end else begin
              next_fair_cnt = 8'(fair_cnt - 8'h01);
            end
          end
        end
      end
    endcase
    // Broken masters stay out unless refresh finds every enabled, unbroken requester served
    // A break found in the same cycle survives the refresh
    if (cfg_bmrf && |broken && &(served | broken | ~cfg_en)) begin
      next_broken = next_broken & ~broken;
      next_served = 5'h00;
    end
    next_gnt = (next_state == pab_pkg::ST_IDLE) ? 5'h00 : onehot(next_owner);
    if (cfg_tog && next_state == pab_pkg::ST_OWN
        && next_tog_cnt == TOG_STEP) begin
      next_gnt = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state    <= pab_pkg::ST_IDLE;
      owner    <= 3'd0;
      last     <= 3'd4;
      fair_cnt <= 8'h00;
      bm_cnt   <= 8'h00;
      tog_cnt  <= 2'd0;
      broken   <= 5'h00;
      served   <= 5'h00;
      gnt_q    <= 5'h00;
    end else begin
      state    <= next_state;
      owner    <= next_owner;
      last     <= next_last;
      fair_cnt <= next_fair_cnt;
      bm_cnt   <= next_bm_cnt;
      tog_cnt  <= next_tog_cnt;
      broken   <= next_broken;
      served   <= next_served;
      gnt_q    <= next_gnt;
    end
  end

  assign int_gnt     = gnt_q[0];
  assign gnt_n       = ~gnt_q[4:1];
  assign broken_mask = broken;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_fall;
    state == pab_pkg::ST_WAIT && frame_fall && own_ok && !cfg_ext;
  endsequence

  sequence s_hold;
    state == pab_pkg::ST_OWN && cfg_tog && own_ok && !cfg_ext;
  endsequence

  chk_ext_no_grant: assert property (cfg_ext |=> gnt_q == 5'h00)
    else $error("grant while external arbiter selected");
  chk_bm_count: assert property (
    (state == pab_pkg::ST_WAIT && next_state == pab_pkg::ST_WAIT
     && cfg_bmto && bus_idle && !frame_fall)
    |=> bm_cnt == 8'($past(bm_cnt) + 8'h01))
    else $error("broken-master count did not advance");
  chk_bm_expire: assert property (
    (state == pab_pkg::ST_WAIT && own_ok && !cfg_ext && !frame_fall
     && cfg_bmto && bus_idle && bm_cnt == BM_LAST)
    |=> gnt_q == 5'h00 && broken[$past(owner)])
    else $error("grant not withdrawn on broken-master expiry");
  chk_broken_sticky: assert property (
    !cfg_bmrf |=> (broken & $past(broken)) == $past(broken))
    else $error("broken master released without refresh");
  chk_refresh_clear: assert property (
    (cfg_bmrf && |broken && &(served | broken | ~cfg_en))
    |=> (broken & $past(broken)) == 5'h00)
    else $error("broken state not refreshed");
  chk_fair_reload: assert property (
    (state == pab_pkg::ST_IDLE && next_state == pab_pkg::ST_WAIT)
    |=> fair_cnt == $past(cfg_fair))
    else $error("fairness counter not reloaded");
  chk_fair_armed: assert property (
    state == pab_pkg::ST_WAIT |=> fair_cnt == $past(fair_cnt))
    else $error("fairness counter moved before FRAME# fell");
  chk_fair_zero: assert property (
    (state == pab_pkg::ST_OWN && cfg_fair == 8'h00 && own_ok && !cfg_ext)
    |=> state == pab_pkg::ST_OWN)
    else $error("grant removed with fairness zero");
  chk_gnt_toggle: assert property (
    (s_fall ##1 s_hold) |=> gnt_q == 5'h00)
    else $error("GNT# not released two clocks after FRAME#");
  chk_no_toggle: assert property (
    (!cfg_tog && next_state == pab_pkg::ST_OWN) |=> gnt_q != 5'h00)
    else $error("GNT# released with toggling off");
  chk_disabled_out: assert property (
    (gnt_q & ~$past(cfg_en)) == 5'h00)
    else $error("disabled requester granted");
  chk_high_first: assert property (
    (state == pab_pkg::ST_IDLE && !cfg_ext && |(elig & cfg_prio))
    |=> (gnt_q & $past(cfg_prio)) != 5'h00 && $onehot(gnt_q))
    else $error("low-priority requester won over high");

endmodule

// file: bench/pab_master_model.sv
// Four external masters on the secondary bus.
// Assumes registered grants; FRAME# and IRDY# are pulled up when released.
module pab_master_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [4:1] want,
  input  wire logic [4:1] mute,
  input  wire logic [4:1] gnt_n,
  output logic      [4:1] req_n,
  output logic            frame_n,
  output logic            irdy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:1] drv;
  logic [4:1] g_prev;
  // Pull-up level whenever no master drives
  assign frame_n = ~|drv;
  assign irdy_n  = ~|drv;
  always_ff @(posedge clk) begin
    g_prev <= gnt_n;
    req_n  <= sys_rst ? 4'hF : ~want;
    for (int i = 1; i <= 4; i++) begin
      // A single-cycle grant release does not end a transfer
      if (sys_rst)
        drv[i] <= 1'b0;
      else if (drv[i] && (!want[i] || (gnt_n[i] && g_prev[i])))
        drv[i] <= 1'b0;
      else if (!gnt_n[i] && want[i] && !mute[i] && drv == 4'h0)
        drv[i] <= 1'b1;
    end
  end
endmodule

// file: bench/tb_pab_arbiter.sv
// Self-checking bench of the secondary-bus arbiter.
// Assumes the design package, header and modules are compiled first.
module tb_pab_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, cfg_sel, cfg_wr, int_req, int_gnt;
  logic        frame_n, irdy_n;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd_v;
  logic [4:1]  req_n, gnt_n, want, mute;
  logic [4:0]  broken_mask, g;
  int          n_mismatch, checked, n, h2, h8, hb, hc;
  assign g = {~gnt_n, int_gnt};

  pab_arbiter #(.BM_CYCLES(4)) dut (.clk(clk), .sys_rst(sys_rst),
    .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .int_req(int_req), .int_gnt(int_gnt), .req_n(req_n), .gnt_n(gnt_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .broken_mask(broken_mask));
  pab_master_model mm (.clk(clk), .sys_rst(sys_rst), .want(want),
    .mute(mute), .gnt_n(gnt_n), .req_n(req_n), .frame_n(frame_n),
    .irdy_n(irdy_n));

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task access(input logic w, input logic [7:0] a, input logic [3:0] be,
              input logic [31:0] d);
    @(posedge clk);
    cfg_sel   <= 1'b1;
    cfg_wr    <= w;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_sel <= 1'b0;
    #1 rd_v = cfg_rdata;
  endtask
  // Bounded wait for grant bit i to reach lv; k counts the cycles
  task wt(input int i, input logic lv, output int k);
    k = 0;
    #1;
    while (g[i] !== lv && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task lowc(input int i, output int c);
    c = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (g[i] !== 1'b1) c++;
    end
  endtask
  // Master 1 owns the bus, master 3 then contends; h is the hold time
  task fair(input logic [31:0] w, output int h);
    int k;
    access(1'b1, 8'h48, 4'hF, w);
    @(posedge clk) want <= 4'h1;
    wt(1, 1'b1, k);
    @(posedge clk) want <= 4'h5;
    wt(1, 1'b0, h);
    @(posedge clk) want <= 4'h0;
    cyc(12);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    cfg_sel = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    int_req = 1'b0;
    want = 4'h0;
    mute = 4'h0;
    cyc(5);
    sys_rst <= 1'b0;
    access(1'b0, 8'h48, 4'hF, 32'h0);
    cmp(rd_v, 32'h0040_801F);
    access(1'b0, 8'h4C, 4'hF, 32'h0);
    cmp(rd_v, 32'h0);
    access(1'b1, 8'h48, 4'h1, 32'h0);
    access(1'b0, 8'h48, 4'hF, 32'h0);
    cmp(rd_v, 32'h0040_8000);
    @(posedge clk) int_req <= 1'b1;
    cyc(10);
    #1 cmp(g, 5'h00);
    access(1'b1, 8'h48, 4'hF, 32'hFFFF_FFFF);
    access(1'b0, 8'h48, 4'hF, 32'h0);
    cmp(rd_v, 32'h07DF_FE1F);
    @(posedge clk) want <= 4'h1;
    cyc(20);
    #1 cmp(g, 5'h00);
    access(1'b1, 8'h48, 4'hF, 32'h0040_801F);
    wt(0, 1'b1, n);
    cmp(g, 5'h01);
    @(posedge clk) int_req <= 1'b0;
    wt(1, 1'b1, n);
    cmp(g, 5'h02);
    lowc(1, hc);
    cmp(hc, 0);
    @(posedge clk) want <= 4'h0;
    cyc(12);
    access(1'b1, 8'h48, 4'hF, 32'h0050_801F);
    @(posedge clk) want <= 4'h1;
    wt(1, 1'b1, n);
    lowc(1, hc);
    cmp(hc, 1);
    @(posedge clk) want <= 4'h0;
    cyc(12);
    fair(32'h0040_201F, h2);
    fair(32'h0040_801F, h8);
    fair(32'h0040_801F, hb);
    cmp(h8 - h2, 6);
    cmp(hb, h8);
    fair(32'h0040_001F, hc);
    cmp(hc, 300);
    access(1'b1, 8'h48, 4'hF, 32'h0440_801F);
    @(posedge clk) want <= 4'h9;
    wt(4, 1'b1, n);
    cmp(g, 5'h10);
    @(posedge clk) want <= 4'h0;
    cyc(12);
    access(1'b1, 8'h48, 4'hF, 32'h0040_841F);
    @(posedge clk) begin
      mute <= 4'h2;
      want <= 4'h2;
    end
    wt(2, 1'b1, n);
    wt(2, 1'b0, n);
    cmp(n >= 4 && n <= 6, 1);
    cmp(broken_mask, 5'h04);
    @(posedge clk) want <= 4'h0;
    cyc(3);
    @(posedge clk) want <= 4'h2;
    cyc(30);
    #1 cmp(g, 5'h00);
    access(1'b1, 8'h48, 4'hF, 32'h0040_8C03);
    @(posedge clk) int_req <= 1'b1;
    wt(0, 1'b1, n);
    @(posedge clk) begin
      int_req <= 1'b0;
      want    <= 4'h1;
    end
    wt(1, 1'b1, n);
    @(posedge clk) want <= 4'h0;
    cyc(10);
    #1 cmp(broken_mask, 5'h00);
    close_out();
  end
endmodule
